// >>> bench/asc_remote.sv
// Behavioural far-end serial transceiver that faces the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"

module asc_remote (
	input wire logic pclk,
	input wire logic txd,
	output logic rxd
);
	localparam int BIT = `ASC_BIT_CYC;
	logic [7:0] got;
	logic got_stop;
	int got_cnt = 0;

	// The line idles high between frames, as a pulled-up serial line does
	initial rxd = 1'b1;

	// Send one 8N1 character LSB first; returns at the end of the stop bit
	task automatic send(input logic [7:0] c);
		rxd <= 1'b0;
		repeat (BIT) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			rxd <= c[i];
			repeat (BIT) @(posedge pclk);
		end
		rxd <= 1'b1;
		repeat (BIT) @(posedge pclk);
	endtask : send

	// Sample mid-bit after each start edge; parity is left to the bench to judge
	initial forever begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge pclk);
			got[i] = txd;
		end
		repeat (BIT) @(posedge pclk);
		got_stop = txd;
		got_cnt++;
	end
endmodule : asc_remote

`default_nettype wire

// >>> bench/async_serial_control_bits_test.sv
// Self-checking bench for the serial control block over APB and the serial line
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"

module async_serial_control_bits_test;
	localparam int BIT = `ASC_BIT_CYC;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, txd, rxd, irq, last_err;
	int fails = 0;
	int compares = 0;

	always #20 pclk = ~pclk;

	asc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd), .irq(irq));
	asc_remote remote (.pclk(pclk), .txd(txd), .rxd(rxd));

	// Parity bit that makes the character's count of ones even, or odd when asked
	function automatic logic par(input logic [6:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction : par

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	task automatic timeout();
		fails++;
		$display("ERROR at %0t: wait ran out", $time);
		complete_run();
	endtask : timeout

	// One APB transfer; holds the request until pready is seen high at an edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) timeout();
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(a, 1'b1, d, r);
	endtask : wr

	// Count cycles until irq rises, giving up after lim cycles
	task automatic wait_irq(input int lim, output int n);
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
		if (irq !== 1'b1) timeout();
	endtask : wait_irq

	initial begin
		logic [31:0] r;
		logic [7:0] v;
		int n;
		void'($urandom(32'hdd8a9310));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(`ASC_OFF_CTRL2, 1'b0, 32'h0, r);
		chk(r, 32'(`ASC_C2_RST));
		apb(`ASC_OFF_STAT, 1'b0, 32'h0, r);
		chk(r, 32'(`ASC_ST_RST));
		apb(8'h10, 1'b0, 32'h0, r);
		chk(32'(last_err), 32'h1);
		// Every enable pattern against tx empty and tx done, both set after reset
		for (int k = 0; k < 16; k++) begin
			wr(`ASC_OFF_CTRL2, 32'(k) << 4);
			apb(`ASC_OFF_CTRL2, 1'b0, 32'h0, r);
			chk(r, 32'(k) << 4);
			chk(32'(irq), 32'(|(k[3:2])));
		end
		// Transmit under each parity setting; odd select alone must change nothing
		for (int k = 0; k < 4; k++) begin
			v = 8'($urandom);
			wr(`ASC_OFF_CTRL1, 32'(k));
			wr(`ASC_OFF_CTRL2, (k == 0) ? 32'hc8 : 32'h48);
			n = remote.got_cnt;
			wr(`ASC_OFF_DATA, 32'(v));
			for (int t = 0; t < 4000 && remote.got_cnt == n; t++) @(posedge pclk);
			if (remote.got_cnt == n) timeout();
			if (k[1]) v[7] = par(v[6:0], k[0]);
			chk(32'(remote.got), 32'(v));
			chk(32'(remote.got_stop), 32'h1);
			repeat (2 * BIT) @(posedge pclk);
			chk(32'(irq), 32'h1);
		end
		// Receive; k=3 carries a wrong parity bit, k=0 runs with rx irq off
		for (int k = 0; k < 4; k++) begin
			v = 8'($urandom);
			if (k[1]) v[7] = par(v[6:0], k[0]) ^ (k == 3);
			wr(`ASC_OFF_CTRL1, 32'(k));
			wr(`ASC_OFF_CTRL2, (k == 0) ? 32'h04 : 32'h24);
			wr(`ASC_OFF_STAT, 32'hff);
			remote.send(v);
			repeat (4) @(posedge pclk);
			chk(32'(irq), 32'(k != 0));
			apb(`ASC_OFF_STAT, 1'b0, 32'h0, r);
			chk(32'(r[5]), 32'h1);
			chk(32'(r[0]), 32'(k == 3));
			apb(`ASC_OFF_DATA, 1'b0, 32'h0, r);
			chk(32'(r[7:0]), 32'(v));
		end
		// Idle after an all-ones character, counted from start bit and from stop bit
		for (int k = 0; k < 2; k++) begin
			wr(`ASC_OFF_CTRL1, 32'(k) << `ASC_C1_IDLE_FROM_STOP);
			wr(`ASC_OFF_CTRL2, 32'h14);
			wr(`ASC_OFF_STAT, 32'hff);
			remote.send(8'hff);
			wait_irq(12 * BIT, n);
			chk(32'(n >= (k ? 9 * BIT : BIT / 2) && n <= (k ? 10 * BIT : 3 * BIT / 2)),
				32'h1);
			wr(`ASC_OFF_STAT, 32'h10);
			chk(32'(irq), 32'h0);
		end
		// Asleep in address-mark mode: a plain character is dropped, a marked one wakes
		wr(`ASC_OFF_CTRL1, 32'h1 << `ASC_C1_WAKE);
		wr(`ASC_OFF_CTRL2, 32'h26);
		wr(`ASC_OFF_STAT, 32'hff);
		remote.send(8'h41);
		repeat (4) @(posedge pclk);
		chk(32'(irq), 32'h0);
		remote.send(8'hc2);
		repeat (4) @(posedge pclk);
		chk(32'(irq), 32'h1);
		apb(`ASC_OFF_CTRL2, 1'b0, 32'h0, r);
		chk(r, 32'h24);
		apb(`ASC_OFF_DATA, 1'b0, 32'h0, r);
		chk(32'(r[7:0]), 32'hc2);
		// Asleep in idle-line mode: the character is dropped, the idle line wakes
		wr(`ASC_OFF_CTRL1, 32'h0);
		wr(`ASC_OFF_CTRL2, 32'h16);
		wr(`ASC_OFF_STAT, 32'hff);
		remote.send(8'h5a);
		wait_irq(12 * BIT, n);
		apb(`ASC_OFF_CTRL2, 1'b0, 32'h0, r);
		chk(r, 32'h14);
		apb(`ASC_OFF_STAT, 1'b0, 32'h0, r);
		chk(32'(r[5:4]), 32'h1);
		complete_run();
	end
endmodule : async_serial_control_bits_test

`default_nettype wire

// >>> hdl/asc_top.sv
// Asynchronous serial port with control bits, status flags and APB registers
// What this block does
// - Wake select 0 wakes on idle line, 1 wakes on address mark
// - Idle needs 10 or 11 high bit times, by character length
// - Idle type 0 counts from start bit, 1 from stop bit
// - Parity enable generates and checks parity in character MSB
// - Parity type 0 even, 1 odd, over character with parity
// - Receive-full flag requests interrupt when its enable is 1
// - Bit 7 of control two gates transmit-empty interrupt
// - Bit 6 of control two gates transmit-done interrupt
// - Bit 4 of control two gates idle-line interrupt
// - Control two is readable and writable at any time
`timescale 1ns/1ps
`default_nettype none
`include "asc_defines.svh"

module asc_top import asc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic txd,
	input wire logic rxd,
	output logic irq
);

	logic [7:0] c1_q, c2_q, st_q, ev, w1c, dclr;
	asc_fmt_s fmt;
	logic wr, rd_setup, hit, wr_data;
	logic [8:0] txb_q, tx_chr;
	logic txb_full_q, tx_busy_q, tx_load, tx_tick, tx_end;
	logic [9:0] shf_q;
	logic [10:0] frame;
	logic [15:0] tx_div_q, rx_div_q, idle_cnt_q, idle_thr;
	logic [3:0] tx_bits_q, rx_bits_q;
	asc_rx_e rx_q;
	logic [8:0] rsh_q, rx_chr;
	logic rx_tick, rx_half, rx_done, addr_mark, deliver, wake_clr;
	asc_rxfr_s rxf, rxb_q;
	logic armed_q, hold, idle_evt, rwu;

	// Format bits gathered for readability
	assign fmt.nine = c1_q[`ASC_C1_NINE];
	assign fmt.wake = c1_q[`ASC_C1_WAKE];
	assign fmt.idle_count_from_stop = c1_q[`ASC_C1_IDLE_FROM_STOP];
	assign fmt.parity_enable = c1_q[`ASC_C1_PAR_EN];
	assign fmt.parity_odd_select = c1_q[`ASC_C1_PAR_ODD];
	assign rwu = c2_q[`ASC_C2_RWU];

	// Bus strobes; zero wait states, so pready is constant
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wr_data = wr & (paddr == `ASC_OFF_DATA);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// Address decode
	always_comb begin
		case (paddr)
			`ASC_OFF_CTRL1, `ASC_OFF_CTRL2, `ASC_OFF_STAT, `ASC_OFF_DATA: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// Read data is captured in the setup cycle so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			case (paddr)
				`ASC_OFF_CTRL1: prdata <= {24'h0, c1_q};
				`ASC_OFF_CTRL2: prdata <= {24'h0, c2_q};
				`ASC_OFF_STAT: prdata <= {24'h0, st_q};
				`ASC_OFF_DATA: prdata <= {23'h0, rxb_q.chr};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// Control one holds the frame format
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c1_q <= `ASC_C1_RST;
		end else if (wr && paddr == `ASC_OFF_CTRL1) begin
			c1_q <= pwdata[7:0];
		end
	end

	// Control two: a software write wins over the hardware wakeup clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c2_q <= `ASC_C2_RST;
		end else if (wr && paddr == `ASC_OFF_CTRL2) begin
			c2_q <= pwdata[7:0];
		end else if (wake_clr) begin
			c2_q[`ASC_C2_RWU] <= 1'b0;
		end
	end

	// Event vector in status layout
	always_comb begin
		ev = 8'h00;
		ev[`ASC_ST_TXE] = tx_load;
		ev[`ASC_ST_TXC] = tx_end & ~txb_full_q;
		ev[`ASC_ST_RXF] = deliver;
		ev[`ASC_ST_IDLE] = idle_evt;
		ev[`ASC_ST_FERR] = deliver & rxf.ferr;
		ev[`ASC_ST_PERR] = deliver & rxf.perr;
		w1c = (wr && paddr == `ASC_OFF_STAT) ? pwdata[7:0] : 8'h00;
		dclr = 8'h00;
		dclr[`ASC_ST_TXE] = wr_data;
		dclr[`ASC_ST_TXC] = wr_data;
	end

	// Sticky flags; a set in the same cycle as a clear wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= `ASC_ST_RST;
		end else begin
			st_q <= (st_q & ~w1c & ~dclr) | ev;
		end
	end

	// Single request line; each enable gates its flag
	// Idle flag gated the same way
	assign irq = |(st_q[`ASC_IRQ_HI:`ASC_IRQ_LO] & c2_q[`ASC_IRQ_HI:`ASC_IRQ_LO]);

	// Transmit holding buffer; a write during a load keeps the new byte
	assign tx_load = txb_full_q & ~tx_busy_q & c2_q[`ASC_C2_TE];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txb_q <= 9'h000;
			txb_full_q <= 1'b0;
		end else if (wr_data) begin
			txb_q <= pwdata[8:0];
			txb_full_q <= 1'b1;
		end else if (tx_load) begin
			txb_full_q <= 1'b0;
		end
	end

	// Parity replaces the character MSB when enabled
	always_comb begin
		tx_chr = fmt.nine ? txb_q : {1'b0, txb_q[7:0]};
		if (fmt.parity_enable) begin
			if (fmt.nine) begin
				tx_chr[8] = (^txb_q[7:0]) ^ fmt.parity_odd_select;
			end else begin
				tx_chr[7] = (^txb_q[6:0]) ^ fmt.parity_odd_select;
			end
		end
		frame = fmt.nine ? {1'b1, tx_chr, 1'b0} : {2'b11, tx_chr[7:0], 1'b0};
	end

	// Transmit shifter, LSB first, one bit per baud period
	assign tx_tick = tx_div_q == 16'(`ASC_BIT_CYC - 1);
	assign tx_end = tx_busy_q & tx_tick & (tx_bits_q == 4'h1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy_q <= 1'b0;
			tx_div_q <= 16'h0000;
			tx_bits_q <= 4'h0;
			shf_q <= 10'h3ff;
			txd <= 1'b1;
		end else if (tx_load) begin
			tx_busy_q <= 1'b1;
			tx_div_q <= 16'h0000;
			tx_bits_q <= fmt.nine ? 4'(`ASC_FRAME_9) : 4'(`ASC_FRAME_8);
			shf_q <= frame[10:1];
			txd <= 1'b0;
		end else if (tx_busy_q) begin
			if (tx_tick) begin
				tx_div_q <= 16'h0000;
				tx_bits_q <= tx_bits_q - 4'h1;
				shf_q <= {1'b1, shf_q[9:1]};
				txd <= (tx_bits_q == 4'h1) ? 1'b1 : shf_q[0];
				if (tx_bits_q == 4'h1) begin
					tx_busy_q <= 1'b0;
				end
			end else begin
				tx_div_q <= tx_div_q + 16'h0001;
			end
		end
	end

	// Receive timing: start bit checked at mid bit, then one sample per bit
	assign rx_half = rx_div_q == 16'(`ASC_BIT_CYC / 2 - 1);
	assign rx_tick = rx_div_q == 16'(`ASC_BIT_CYC - 1);
	assign rx_done = (rx_q == RX_STOP) & rx_tick;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q <= RX_IDLE;
			rx_div_q <= 16'h0000;
			rx_bits_q <= 4'h0;
			rsh_q <= 9'h000;
		end else if (!c2_q[`ASC_C2_RE]) begin
			rx_q <= RX_IDLE;
		end else begin
			case (rx_q)
				RX_IDLE: begin
					rx_div_q <= 16'h0000;
					if (!rxd) begin
						rx_q <= RX_START;
					end
				end
				RX_START: begin
					if (rx_half) begin
						rx_div_q <= 16'h0000;
						rx_bits_q <= fmt.nine ? 4'(`ASC_DATA_9) : 4'(`ASC_DATA_8);
						rx_q <= rxd ? RX_IDLE : RX_DATA;
					end else begin
						rx_div_q <= rx_div_q + 16'h0001;
					end
				end
				RX_DATA: begin
					if (rx_tick) begin
						rx_div_q <= 16'h0000;
						rsh_q <= {rxd, rsh_q[8:1]};
						rx_bits_q <= rx_bits_q - 4'h1;
						if (rx_bits_q == 4'h1) begin
							rx_q <= RX_STOP;
						end
					end else begin
						rx_div_q <= rx_div_q + 16'h0001;
					end
				end
				RX_STOP: begin
					if (rx_tick) begin
						rx_div_q <= 16'h0000;
						rx_q <= RX_IDLE;
					end else begin
						rx_div_q <= rx_div_q + 16'h0001;
					end
				end
				default: rx_q <= RX_IDLE;
			endcase
		end
	end

	// Received character, checks and wakeup decision
	assign rx_chr = fmt.nine ? rsh_q : {1'b0, rsh_q[8:1]};
	assign rxf.chr = rx_chr;
	assign rxf.ferr = ~rxd;
	assign rxf.perr = fmt.parity_enable & ((^rx_chr) != fmt.parity_odd_select);
	assign addr_mark = fmt.nine ? rx_chr[8] : rx_chr[7];
	// Asleep, only an address-mark character in that mode gets through
	assign deliver = rx_done & (~rwu | (fmt.wake & addr_mark));
	assign wake_clr = rwu & (fmt.wake ? (rx_done & addr_mark) : idle_evt);

	// Receive buffer; overrun simply overwrites the older character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxb_q <= '0;
		end else if (deliver) begin
			rxb_q <= rxf;
		end
	end

	// Idle detector; with idle type 1 the count is held at zero through the frame
	assign idle_thr = fmt.nine ? 16'(`ASC_IDLE_BITS_9 * `ASC_BIT_CYC)
		: 16'(`ASC_IDLE_BITS_8 * `ASC_BIT_CYC);
	assign hold = ~rxd | (fmt.idle_count_from_stop & (rx_q != RX_IDLE));
	assign idle_evt = ~hold & c2_q[`ASC_C2_RE] & armed_q & (idle_cnt_q == idle_thr - 16'h0001);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt_q <= 16'h0000;
		end else if (hold) begin
			idle_cnt_q <= 16'h0000;
		end else if (idle_cnt_q < idle_thr) begin
			idle_cnt_q <= idle_cnt_q + 16'h0001;
		end
	end

	// Idle is reported once per burst, re-armed by a received character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_q <= 1'b0;
		end else if (rx_done) begin
			armed_q <= 1'b1;
		end else if (idle_evt) begin
			armed_q <= 1'b0;
		end
	end

	// Checking helpers: raw high run and time since the receiver left a frame
	logic [15:0] hi_run_q, since_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_run_q <= 16'h0000;
			since_q <= 16'h0000;
		end else begin
			hi_run_q <= !rxd ? 16'h0000 : (hi_run_q + {15'h0, ~&hi_run_q});
			since_q <= (rx_q != RX_IDLE) ? 16'h0000 : (since_q + {15'h0, ~&since_q});
		end
	end

	// Wakeup, idle, parity, interrupt and register checks
	property p_wake_am;
		@(posedge pclk) disable iff (!presetn)
		rx_done && fmt.wake && rwu && addr_mark && !wr |=> !rwu && st_q[`ASC_ST_RXF];
	endproperty
	a_wake_am: assert property (p_wake_am) else $error("address mark did not wake");
	property p_wake_idle;
		@(posedge pclk) disable iff (!presetn)
		idle_evt && !fmt.wake && rwu && !wr |=> !rwu;
	endproperty
	a_wake_idle: assert property (p_wake_idle) else $error("idle line did not wake");
	property p_idle_len;
		@(posedge pclk) disable iff (!presetn)
		idle_evt |-> hi_run_q >= idle_thr - 16'h0001;
	endproperty
	a_idle_len: assert property (p_idle_len) else $error("idle flagged too early");
	property p_idle_stop;
		@(posedge pclk) disable iff (!presetn)
		idle_evt && fmt.idle_count_from_stop |-> since_q >= idle_thr - 16'h0001;
	endproperty
	a_idle_stop: assert property (p_idle_stop) else $error("idle counted inside frame");
	property p_tx_par;
		@(posedge pclk) disable iff (!presetn)
		tx_load && fmt.parity_enable |=>
			(($past(fmt.nine) ? ^shf_q[8:0] : ^shf_q[7:0]) == $past(fmt.parity_odd_select));
	endproperty
	a_tx_par: assert property (p_tx_par) else $error("bad transmit parity");
	property p_rx_par;
		@(posedge pclk) disable iff (!presetn)
		deliver && fmt.parity_enable && ((^rx_chr) != fmt.parity_odd_select) |=> st_q[`ASC_ST_PERR];
	endproperty
	a_rx_par: assert property (p_rx_par) else $error("parity error missed");
	property p_rxf_irq;
		@(posedge pclk) disable iff (!presetn)
		deliver && c2_q[`ASC_C2_RXF_IRQ_EN] && !wr |=> irq;
	endproperty
	a_rxf_irq: assert property (p_rxf_irq) else $error("no receive interrupt");
	property p_txe_irq;
		@(posedge pclk) disable iff (!presetn)
		tx_load && c2_q[`ASC_C2_TXE_IRQ_EN] && !wr |=> irq && st_q[`ASC_ST_TXE];
	endproperty
	a_txe_irq: assert property (p_txe_irq) else $error("no transmit empty interrupt");
	property p_txc_irq;
		@(posedge pclk) disable iff (!presetn)
		tx_end && !txb_full_q && c2_q[`ASC_C2_TXC_IRQ_EN] && !wr |=> irq;
	endproperty
	a_txc_irq: assert property (p_txc_irq) else $error("no transmit done interrupt");
	property p_idle_irq;
		@(posedge pclk) disable iff (!presetn)
		idle_evt && c2_q[`ASC_C2_IDLE_IRQ_EN] && !wr |=> irq;
	endproperty
	a_idle_irq: assert property (p_idle_irq) else $error("no idle interrupt");
	property p_c2_write;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == `ASC_OFF_CTRL2 |=> c2_q == $past(pwdata[7:0]);
	endproperty
	a_c2_write: assert property (p_c2_write) else $error("control two write lost");
	property p_irq_src;
		@(posedge pclk) disable iff (!presetn)
		irq |-> (st_q[`ASC_ST_RXF] && c2_q[`ASC_C2_RXF_IRQ_EN])
			|| (st_q[`ASC_ST_TXE] && c2_q[`ASC_C2_TXE_IRQ_EN])
			|| (st_q[`ASC_ST_TXC] && c2_q[`ASC_C2_TXC_IRQ_EN])
			|| (st_q[`ASC_ST_IDLE] && c2_q[`ASC_C2_IDLE_IRQ_EN]);
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("interrupt without source");
	c_rx_char: cover property (@(posedge pclk) disable iff (!presetn) deliver);
	c_idle: cover property (@(posedge pclk) disable iff (!presetn) idle_evt);
	c_tx_done: cover property (@(posedge pclk) disable iff (!presetn) tx_end && !txb_full_q);

endmodule : asc_top
`default_nettype wire

// >>> inc/asc_defines.svh
// Offsets, field positions, reset values and timing for the serial control block
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
`define ASC_CLK_HZ 25000000
`define ASC_BAUD_HZ 115200
`define ASC_BIT_CYC (`ASC_CLK_HZ / `ASC_BAUD_HZ)
`define ASC_IDLE_BITS_8 10
`define ASC_IDLE_BITS_9 11
`define ASC_FRAME_8 10
`define ASC_FRAME_9 11
`define ASC_DATA_8 8
`define ASC_DATA_9 9
`define ASC_OFF_CTRL1 8'h00
`define ASC_OFF_CTRL2 8'h04
`define ASC_OFF_STAT 8'h08
`define ASC_OFF_DATA 8'h0c
`define ASC_C1_NINE 4
`define ASC_C1_WAKE 3
`define ASC_C1_IDLE_FROM_STOP 2
`define ASC_C1_PAR_EN 1
`define ASC_C1_PAR_ODD 0
`define ASC_C2_TXE_IRQ_EN 7
`define ASC_C2_TXC_IRQ_EN 6
`define ASC_C2_RXF_IRQ_EN 5
`define ASC_C2_IDLE_IRQ_EN 4
`define ASC_C2_TE 3
`define ASC_C2_RE 2
`define ASC_C2_RWU 1
`define ASC_ST_TXE 7
`define ASC_ST_TXC 6
`define ASC_ST_RXF 5
`define ASC_ST_IDLE 4
`define ASC_ST_FERR 1
`define ASC_ST_PERR 0
`define ASC_IRQ_HI 7
`define ASC_IRQ_LO 4
`define ASC_C1_RST 8'h00
`define ASC_C2_RST 8'h00
`define ASC_ST_RST 8'hc0
`endif

// >>> inc/asc_pkg.sv
// Types shared by the serial control block
package asc_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asc_rx_e;
	typedef struct packed {
		logic nine;
		logic wake;
		logic idle_count_from_stop;
		logic parity_enable;
		logic parity_odd_select;
	} asc_fmt_s;
	typedef struct packed {
		logic [8:0] chr;
		logic ferr;
		logic perr;
	} asc_rxfr_s;
endpackage : asc_pkg
